/* File: src/pssl_pkg.sv */
package pssl_pkg;

   // register offsets (byte addresses, one word each)
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_DONE_WIN   = 8'h04;
   localparam logic [7:0] OFS_NEAR_WIN   = 8'h08;
   localparam logic [7:0] OFS_ROT_LIM    = 8'h0C;
   localparam logic [7:0] OFS_LIN_LIM    = 8'h10;
   localparam logic [7:0] OFS_MAX_SPD    = 8'h14;
   localparam logic [7:0] OFS_OVS_SPD    = 8'h18;
   localparam logic [7:0] OFS_EXT_LIM    = 8'h1C;
   localparam logic [7:0] OFS_STATUS     = 8'h20;
   localparam logic [7:0] OFS_IRQ_STAT   = 8'h24;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h28;
   localparam logic [7:0] OFS_ALLOC      = 8'h2C;

   // control field positions
   localparam int CTRL_TIMING_LSB = 0;   // 2 bits
   localparam int CTRL_SRC_BIT    = 2;
   localparam int CTRL_BASIS_BIT  = 3;
   localparam int CTRL_LINEAR_BIT = 4;
   localparam int CTRL_TORQUE_BIT = 5;

   // status / interrupt bit positions
   localparam int ST_DONE_BIT  = 0;
   localparam int ST_NEAR_BIT  = 1;
   localparam int ST_LIMIT_BIT = 2;

   // allocation field positions
   localparam int AL_DONE_BIT  = 0;
   localparam int AL_NEAR_BIT  = 1;
   localparam int AL_LIMIT_BIT = 2;

   // widths and ranges
   localparam int          WIN_W   = 31;
   localparam int          SPD_W   = 16;
   localparam int          POS_W   = 32;
   localparam logic [30:0] WIN_MAX = 31'h4000_0000;
   localparam logic [15:0] LIM_MAX = 16'h2710;

   // reset values
   localparam logic [1:0]  RST_TIMING   = 2'h0;
   localparam logic        RST_SRC      = 1'b1;
   localparam logic        RST_BASIS    = 1'b0;
   localparam logic [30:0] RST_DONE_WIN = 31'h0000_0007;
   localparam logic [30:0] RST_NEAR_WIN = 31'h4000_0000;
   localparam logic [15:0] RST_LIM      = 16'h2710;
   localparam logic [15:0] RST_MAX_SPD  = 16'h2710;
   localparam logic [15:0] RST_OVS_SPD  = 16'h2AF8;

   typedef enum logic [1:0] {
      TIMING_DEV_ONLY = 2'h0,
      TIMING_FILT_REF = 2'h1,
      TIMING_IN_REF   = 2'h2
   } pssl_timing_t;

   // motion sample of one control cycle
   typedef struct packed {
      logic signed [31:0] deviation;
      logic               filt_ref_zero;
      logic               in_ref_zero;
      logic [15:0]        speed_abs;
   } pssl_sample_t;

   typedef struct packed {
      logic done;
      logic near;
      logic limited;
   } pssl_flags_t;

endpackage

/* File: src/pssl_pos_cmp.sv */
`timescale 1ns/1ps
`default_nettype none
// deviation window comparators, purely combinational
module pssl_pos_cmp (
   input  wire logic signed [31:0]     deviation_i,
   input  wire logic                   filt_ref_zero_i,
   input  wire logic                   in_ref_zero_i,
   input  wire logic [1:0]             timing_i,
   input  wire logic [30:0]            done_win_i,
   input  wire logic [30:0]            near_win_i,
   output logic                        done_o,
   output logic                        near_o
);
   logic [31:0] abs_dev;
   logic        in_done;

   // magnitude of the deviation; most negative value gives 2^31 as unsigned
   always_comb begin
      abs_dev = deviation_i[31] ? (32'h0000_0000 - deviation_i) : deviation_i;
      in_done = (abs_dev <= {1'b0, done_win_i});
   end

   // timing selector adds a zero-reference condition
   always_comb begin
      case (timing_i)
         pssl_pkg::TIMING_DEV_ONLY: done_o = in_done;
         pssl_pkg::TIMING_FILT_REF: done_o = in_done & filt_ref_zero_i;
         pssl_pkg::TIMING_IN_REF:   done_o = in_done & in_ref_zero_i;
         default:                   done_o = in_done;
      endcase
   end

   // signed deviation compared, so overshoot counts as near
   always_comb begin
      near_o = ($signed(deviation_i) <= $signed({1'b0, near_win_i}));
   end
endmodule
`default_nettype wire

/* File: src/pssl_spd_lim.sv */
`timescale 1ns/1ps
`default_nettype none
// effective speed limit selection, combinational
module pssl_spd_lim (
   input  wire logic [15:0]            rot_lim_i,
   input  wire logic [15:0]            lin_lim_i,
   input  wire logic                   linear_i,
   input  wire logic                   basis_i,
   input  wire logic [15:0]            max_spd_i,
   input  wire logic [15:0]            ovs_spd_i,
   input  wire logic [15:0]            ext_lim_i,
   input  wire logic                   src_ext_i,
   output logic [15:0]                 limit_o
);
   logic [15:0] param_lim;
   logic [15:0] basis_spd;
   logic [15:0] int_lim;

   // parameter per motor type, basis per selector
   always_comb begin
      param_lim = linear_i ? lin_lim_i : rot_lim_i;
      basis_spd = basis_i ? ovs_spd_i : max_spd_i;
      // a parameter above the maximum speed yields the basis speed
      if (param_lim > max_spd_i) begin
         int_lim = basis_spd;
      end else begin
         int_lim = (param_lim < basis_spd) ? param_lim : basis_spd;
      end
      // reserved source setting falls back to internal only
      if (src_ext_i) begin
         limit_o = (ext_lim_i < int_lim) ? ext_lim_i : int_lim;
      end else begin
         limit_o = int_lim;
      end
   end
endmodule
`default_nettype wire

/* File: src/pssl_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - selector 0: done when absolute deviation is within done window.
// - selector 1: done also needs filtered position reference at zero.
// - selector 2: done also needs incoming reference input at zero.
// - done window holds 0 to 2^30, resets to 7, applies at once.
// - near when signed deviation is at most the near window.
// - near window holds 1 to 2^30, resets to 2^30, applies at once.
// - near output high when in near region, low otherwise.
// - near reaches its pin only when allocated; otherwise undriven.
// - limited flag high while speed is held at the active limit.
// - in torque control the smaller of external and internal limits applies.
// - source select 1 takes external command; 0 is reserved.
// - basis 0: internal limit is min of max speed and parameter.
// - basis 1: internal limit is min of overspeed speed and parameter.
// - rotary and linear limit parameters, 0 to 10000, default 10000.
// - parameter above max speed yields the selected basis speed.
// - torque mode bounds speed only through the limit function.
module pssl_top (
   input  wire logic                   mclk_i,
   input  wire logic                   reset_n_i,
   input  wire logic [7:0]             addr_i,
   input  wire logic [31:0]            wdata_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   output logic [31:0]                 rdata_o,
   input  wire pssl_pkg::pssl_sample_t sample_i,
   output logic                        positioning_done_out_o,
   output logic                        positioning_done_oe_o,
   output logic                        near_position_out_o,
   output logic                        near_position_oe_o,
   output logic                        speed_limited_out_o,
   output logic                        speed_limited_oe_o,
   output logic [15:0]                 speed_limit_o,
   output logic                        irq_o
);
   // configuration registers
   logic [1:0]  timing_ff,   nxt_timing;
   logic        src_ff,      nxt_src;
   logic        basis_ff,    nxt_basis;
   logic        linear_ff,   nxt_linear;
   logic        torque_ff,   nxt_torque;
   logic [30:0] done_win_ff, nxt_done_win;
   logic [30:0] near_win_ff, nxt_near_win;
   logic [15:0] rot_lim_ff,  nxt_rot_lim;
   logic [15:0] lin_lim_ff,  nxt_lin_lim;
   logic [15:0] max_spd_ff,  nxt_max_spd;
   logic [15:0] ovs_spd_ff,  nxt_ovs_spd;
   logic [15:0] ext_lim_ff,  nxt_ext_lim;
   logic [2:0]  alloc_ff,    nxt_alloc;
   logic [2:0]  mask_ff,     nxt_mask;
   logic [2:0]  stat_ff,     nxt_stat;
   // flag and output state
   pssl_pkg::pssl_flags_t flags_ff, nxt_flags;
   logic [2:0]  out_ff,  nxt_out;
   logic [2:0]  oe_ff,   nxt_oe;
   logic [15:0] lim_ff,  nxt_lim;
   logic        irq_ff,  nxt_irq;
   logic [31:0] rdata_ff, nxt_rdata;
   // comparator results
   logic        done_raw;
   logic        near_raw;
   logic [15:0] eff_lim;
   logic        limited_raw;
   logic [2:0]  rise;

   // clamp a written window to its legal range
   function automatic logic [30:0] clamp_win(input logic [31:0] v, input logic [30:0] lo);
      logic [31:0] r;
      r = v;
      if (v > {1'b0, pssl_pkg::WIN_MAX}) begin
         r = {1'b0, pssl_pkg::WIN_MAX};
      end
      if (r < {1'b0, lo}) begin
         r = {1'b0, lo};
      end
      return r[30:0];
   endfunction

   // clamp a speed limit parameter to its legal range
   function automatic logic [15:0] clamp_lim(input logic [31:0] v);
      logic [15:0] r;
      r = v[15:0];
      if (v > {16'h0000, pssl_pkg::LIM_MAX}) begin
         r = pssl_pkg::LIM_MAX;
      end
      return r;
   endfunction

   pssl_pos_cmp u_pos_cmp (
      .deviation_i     (sample_i.deviation),
      .filt_ref_zero_i (sample_i.filt_ref_zero),
      .in_ref_zero_i   (sample_i.in_ref_zero),
      .timing_i        (timing_ff),
      .done_win_i      (done_win_ff),
      .near_win_i      (near_win_ff),
      .done_o          (done_raw),
      .near_o          (near_raw)
   );

   pssl_spd_lim u_spd_lim (
      .rot_lim_i  (rot_lim_ff),
      .lin_lim_i  (lin_lim_ff),
      .linear_i   (linear_ff),
      .basis_i    (basis_ff),
      .max_spd_i  (max_spd_ff),
      .ovs_spd_i  (ovs_spd_ff),
      .ext_lim_i  (ext_lim_ff),
      .src_ext_i  (src_ff),
      .limit_o    (eff_lim)
   );

   // speed held at the limit only counts in torque control
   always_comb begin
      limited_raw = torque_ff & (sample_i.speed_abs >= eff_lim);
   end

   // register writes; windows and limits take effect on the next cycle
   always_comb begin
      nxt_timing   = timing_ff;
      nxt_src      = src_ff;
      nxt_basis    = basis_ff;
      nxt_linear   = linear_ff;
      nxt_torque   = torque_ff;
      nxt_done_win = done_win_ff;
      nxt_near_win = near_win_ff;
      nxt_rot_lim  = rot_lim_ff;
      nxt_lin_lim  = lin_lim_ff;
      nxt_max_spd  = max_spd_ff;
      nxt_ovs_spd  = ovs_spd_ff;
      nxt_ext_lim  = ext_lim_ff;
      nxt_alloc    = alloc_ff;
      nxt_mask     = mask_ff;
      if (wr_i) begin
         case (addr_i)
            pssl_pkg::OFS_CTRL: begin
               nxt_timing = wdata_i[pssl_pkg::CTRL_TIMING_LSB +: 2];
               nxt_src    = wdata_i[pssl_pkg::CTRL_SRC_BIT];
               nxt_basis  = wdata_i[pssl_pkg::CTRL_BASIS_BIT];
               nxt_linear = wdata_i[pssl_pkg::CTRL_LINEAR_BIT];
               nxt_torque = wdata_i[pssl_pkg::CTRL_TORQUE_BIT];
            end
            pssl_pkg::OFS_DONE_WIN: begin
               nxt_done_win = clamp_win(wdata_i, 31'h0000_0000);
            end
            pssl_pkg::OFS_NEAR_WIN: begin
               nxt_near_win = clamp_win(wdata_i, 31'h0000_0001);
            end
            pssl_pkg::OFS_ROT_LIM: begin
               nxt_rot_lim = clamp_lim(wdata_i);
            end
            pssl_pkg::OFS_LIN_LIM: begin
               nxt_lin_lim = clamp_lim(wdata_i);
            end
            pssl_pkg::OFS_MAX_SPD: begin
               nxt_max_spd = wdata_i[15:0];
            end
            pssl_pkg::OFS_OVS_SPD: begin
               nxt_ovs_spd = wdata_i[15:0];
            end
            pssl_pkg::OFS_EXT_LIM: begin
               nxt_ext_lim = wdata_i[15:0];
            end
            pssl_pkg::OFS_IRQ_MASK: begin
               nxt_mask = wdata_i[2:0];
            end
            pssl_pkg::OFS_ALLOC: begin
               nxt_alloc = wdata_i[2:0];
            end
            default: begin
               nxt_alloc = alloc_ff;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         timing_ff   <= pssl_pkg::RST_TIMING;
         src_ff      <= pssl_pkg::RST_SRC;
         basis_ff    <= pssl_pkg::RST_BASIS;
         linear_ff   <= 1'b0;
         torque_ff   <= 1'b0;
         done_win_ff <= pssl_pkg::RST_DONE_WIN;
         near_win_ff <= pssl_pkg::RST_NEAR_WIN;
         rot_lim_ff  <= pssl_pkg::RST_LIM;
         lin_lim_ff  <= pssl_pkg::RST_LIM;
         max_spd_ff  <= pssl_pkg::RST_MAX_SPD;
         ovs_spd_ff  <= pssl_pkg::RST_OVS_SPD;
         ext_lim_ff  <= pssl_pkg::RST_LIM;
         alloc_ff    <= 3'h0;
         mask_ff     <= 3'h0;
      end else begin
         timing_ff   <= nxt_timing;
         src_ff      <= nxt_src;
         basis_ff    <= nxt_basis;
         linear_ff   <= nxt_linear;
         torque_ff   <= nxt_torque;
         done_win_ff <= nxt_done_win;
         near_win_ff <= nxt_near_win;
         rot_lim_ff  <= nxt_rot_lim;
         lin_lim_ff  <= nxt_lin_lim;
         max_spd_ff  <= nxt_max_spd;
         ovs_spd_ff  <= nxt_ovs_spd;
         ext_lim_ff  <= nxt_ext_lim;
         alloc_ff    <= nxt_alloc;
         mask_ff     <= nxt_mask;
      end
   end

   // flags sampled every control cycle, pins gated by allocation
   always_comb begin
      nxt_flags.done    = done_raw;
      nxt_flags.near    = near_raw;
      nxt_flags.limited = limited_raw;
      nxt_lim           = eff_lim;
      nxt_out[pssl_pkg::AL_DONE_BIT]  = done_raw & alloc_ff[pssl_pkg::AL_DONE_BIT];
      nxt_out[pssl_pkg::AL_NEAR_BIT]  = near_raw & alloc_ff[pssl_pkg::AL_NEAR_BIT];
      nxt_out[pssl_pkg::AL_LIMIT_BIT] = limited_raw & alloc_ff[pssl_pkg::AL_LIMIT_BIT];
      nxt_oe  = alloc_ff;
      // rising edges feed the sticky status
      rise    = {limited_raw & ~flags_ff.limited,
                 near_raw & ~flags_ff.near,
                 done_raw & ~flags_ff.done};
      // a new event wins over a same-cycle clear
      nxt_stat = stat_ff;
      if (wr_i && (addr_i == pssl_pkg::OFS_IRQ_STAT)) begin
         nxt_stat = stat_ff & ~wdata_i[2:0];
      end
      nxt_stat = nxt_stat | rise;
      nxt_irq  = |(nxt_stat & nxt_mask);
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         flags_ff <= '0;
         out_ff   <= 3'h0;
         oe_ff    <= 3'h0;
         lim_ff   <= 16'h0000;
         stat_ff  <= 3'h0;
         irq_ff   <= 1'b0;
      end else begin
         flags_ff <= nxt_flags;
         out_ff   <= nxt_out;
         oe_ff    <= nxt_oe;
         lim_ff   <= nxt_lim;
         stat_ff  <= nxt_stat;
         irq_ff   <= nxt_irq;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (rd_i) begin
         case (addr_i)
            pssl_pkg::OFS_CTRL: begin
               nxt_rdata = {26'h000_0000, torque_ff, linear_ff, basis_ff, src_ff, timing_ff};
            end
            pssl_pkg::OFS_DONE_WIN: nxt_rdata = {1'b0, done_win_ff};
            pssl_pkg::OFS_NEAR_WIN: nxt_rdata = {1'b0, near_win_ff};
            pssl_pkg::OFS_ROT_LIM:  nxt_rdata = {16'h0000, rot_lim_ff};
            pssl_pkg::OFS_LIN_LIM:  nxt_rdata = {16'h0000, lin_lim_ff};
            pssl_pkg::OFS_MAX_SPD:  nxt_rdata = {16'h0000, max_spd_ff};
            pssl_pkg::OFS_OVS_SPD:  nxt_rdata = {16'h0000, ovs_spd_ff};
            pssl_pkg::OFS_EXT_LIM:  nxt_rdata = {16'h0000, ext_lim_ff};
            pssl_pkg::OFS_STATUS: begin
               nxt_rdata = {13'h0000, lim_ff,
                            flags_ff.limited, flags_ff.near, flags_ff.done};
            end
            pssl_pkg::OFS_IRQ_STAT: nxt_rdata = {29'h0000_0000, stat_ff};
            pssl_pkg::OFS_IRQ_MASK: nxt_rdata = {29'h0000_0000, mask_ff};
            pssl_pkg::OFS_ALLOC:    nxt_rdata = {29'h0000_0000, alloc_ff};
            default:                nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         rdata_ff <= 32'h0000_0000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata_o                = rdata_ff;
   assign positioning_done_out_o = out_ff[pssl_pkg::AL_DONE_BIT];
   assign positioning_done_oe_o  = oe_ff[pssl_pkg::AL_DONE_BIT];
   assign near_position_out_o    = out_ff[pssl_pkg::AL_NEAR_BIT];
   assign near_position_oe_o     = oe_ff[pssl_pkg::AL_NEAR_BIT];
   assign speed_limited_out_o    = out_ff[pssl_pkg::AL_LIMIT_BIT];
   assign speed_limited_oe_o     = oe_ff[pssl_pkg::AL_LIMIT_BIT];
   assign speed_limit_o          = lim_ff;
   assign irq_o                  = irq_ff;
endmodule
`default_nettype wire

/* File: test/pssl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// pin flags, limit and read port of the top
module pssl_chk (
   input  wire logic                   mclk_i,
   input  wire logic                   reset_n_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   input  wire logic [31:0]            rdata_o,
   input  wire pssl_pkg::pssl_sample_t sample_i,
   input  wire logic                   positioning_done_out_o,
   input  wire logic                   positioning_done_oe_o,
   input  wire logic                   near_position_out_o,
   input  wire logic                   near_position_oe_o,
   input  wire logic                   speed_limited_out_o,
   input  wire logic                   speed_limited_oe_o,
   input  wire logic [15:0]            speed_limit_o,
   input  wire logic                   irq_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!reset_n_i);

   // an unallocated flag never shows on its pin
   a_done_gated: assert property (!positioning_done_oe_o |-> !positioning_done_out_o)
      else $error("done pin undriven");
   a_near_gated: assert property (!near_position_oe_o |-> !near_position_out_o)
      else $error("near pin undriven");
   a_lim_gated: assert property (!speed_limited_oe_o |-> !speed_limited_out_o)
      else $error("limit pin undriven");
   // window is at least one, so deviation <= 0 is near
   a_near_behind: assert property (near_position_oe_o &&
      $past(sample_i.deviation) <= 0 |-> near_position_out_o)
      else $error("near missing");
   // zero deviation, references idle: done in every mode
   a_done_zero: assert property (positioning_done_oe_o &&
      $past(sample_i.deviation) == 0 && $past(sample_i.filt_ref_zero) &&
      $past(sample_i.in_ref_zero) |-> positioning_done_out_o)
      else $error("done missing");
   // no done beyond the largest window
   a_done_far: assert property (($past(sample_i.deviation) > 32'sh4000_0000 ||
      $past(sample_i.deviation) < -32'sh4000_0000) |-> !positioning_done_out_o)
      else $error("done too far");
   a_lim_reach: assert property (speed_limited_out_o |->
      $past(sample_i.speed_abs) >= speed_limit_o)
      else $error("limited too early");
   // a write two edges back is the only thing that moves the limit
   a_limit_steady: assert property ($past(reset_n_i) && $past(reset_n_i, 2) &&
      !$past(wr_i, 2) |-> $stable(speed_limit_o))
      else $error("limit moved");
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
      else $error("stray read data");

   // main scenarios
   c_near_rise: cover property ($rose(near_position_out_o));
   c_lim_rise: cover property ($rose(speed_limited_out_o));
   c_irq_rise: cover property ($rose(irq_o));
endmodule
bind pssl_top pssl_chk i_chk (
   .mclk_i,
   .reset_n_i,
   .wr_i,
   .rd_i,
   .rdata_o,
   .sample_i,
   .positioning_done_out_o,
   .positioning_done_oe_o,
   .near_position_out_o,
   .near_position_oe_o,
   .speed_limited_out_o,
   .speed_limited_oe_o,
   .speed_limit_o,
   .irq_o
);
`default_nettype wire

/* File: test/pssl_host.sv */
`timescale 1ns/1ps
`default_nettype none
// register master and motion sample source
module pssl_host (
   input  wire logic                   mclk_i,
   input  wire logic [31:0]            rdata_i,
   output var logic [7:0]              addr_o,
   output var logic [31:0]             wdata_o,
   output var logic                    wr_o,
   output var logic                    rd_o,
   output var pssl_pkg::pssl_sample_t  sample_o
);
   // idle values from time zero
   initial begin
      addr_o = 8'h00;
      wdata_o = 32'h0000_0000;
      wr_o = 1'b0;
      rd_o = 1'b0;
      sample_o = '0;
   end
   // released lines show the inverse, never a stale value
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge mclk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   // data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge mclk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rdata_i;
   endtask
   task automatic put(input logic signed [31:0] dev, input logic fz, input logic iz,
                      input logic [15:0] spd);
      @(posedge mclk_i);
      sample_o <= {dev, fz, iz, spd};
   endtask
endmodule
`default_nettype wire

/* File: test/pssl_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) cmp(32'(g), 32'(e))
module pssl_top_tb;
   logic                   mclk = 1'b0;
   logic                   reset_n = 1'b0;
   logic [7:0]             addr;
   logic [31:0]            wdata;
   logic [31:0]            rdata;
   logic                   wr;
   logic                   rd;
   pssl_pkg::pssl_sample_t smp;
   logic [2:0]             pin;
   logic [2:0]             oe;
   logic [15:0]            lim;
   logic                   irq;
   logic [31:0]            d;
   int                     n_fail = 0;
   int                     n_tests = 0;

   pssl_host i_host (
      .mclk_i   (mclk),
      .rdata_i  (rdata),
      .addr_o   (addr),
      .wdata_o  (wdata),
      .wr_o     (wr),
      .rd_o     (rd),
      .sample_o (smp)
   );
   pssl_top i_dut (
      .mclk_i                 (mclk),
      .reset_n_i              (reset_n),
      .addr_i                 (addr),
      .wdata_i                (wdata),
      .wr_i                   (wr),
      .rd_i                   (rd),
      .rdata_o                (rdata),
      .sample_i               (smp),
      .positioning_done_out_o (pin[0]),
      .positioning_done_oe_o  (oe[0]),
      .near_position_out_o    (pin[1]),
      .near_position_oe_o     (oe[1]),
      .speed_limited_out_o    (pin[2]),
      .speed_limited_oe_o     (oe[2]),
      .speed_limit_o          (lim),
      .irq_o                  (irq)
   );

   // 200 MHz clock
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // flags show a sample one cycle late
   task automatic fl(input logic signed [31:0] dv, input logic fz, input logic iz,
                     input logic [15:0] sp);
      i_host.put(dv, fz, iz, sp);
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic sp(input logic [15:0] s);
      fl(32'sh0000_0000, 1'b1, 1'b1, s);
   endtask
   task automatic t_reset();
      i_host.rd(pssl_pkg::OFS_DONE_WIN, d);
      `CHK(d, 32'h0000_0007);
      i_host.rd(pssl_pkg::OFS_NEAR_WIN, d);
      `CHK(d, 32'h4000_0000);
      i_host.rd(pssl_pkg::OFS_ROT_LIM, d);
      `CHK(d, 32'h0000_2710);
      i_host.rd(pssl_pkg::OFS_LIN_LIM, d);
      `CHK(d, 32'h0000_2710);
      i_host.rd(pssl_pkg::OFS_CTRL, d);
      `CHK(d, 32'h0000_0004);
      i_host.rd(8'h30, d);
      `CHK(d, 32'h0000_0000);
      sp(16'h0000);
      `CHK({oe, pin}, 6'h00);
      $display("test reset done");
   endtask
   // every timing mode against each reference condition
   task automatic t_done();
      logic [1:0] t;
      i_host.wr(pssl_pkg::OFS_ALLOC, 32'h0000_0007);
      for (int k = 0; k < 4; k++) begin
         t = 2'(k);
         i_host.wr(pssl_pkg::OFS_CTRL, {29'h0000_0000, 1'b1, t});
         fl(32'sh0000_0007, 1'b0, 1'b0, 16'h0000);
         `CHK(pin[0], t[0] == t[1]);
         fl(-32'sh0000_0007, 1'b1, 1'b0, 16'h0000);
         `CHK(pin[0], t != 2'h2);
         fl(32'sh0000_0007, 1'b0, 1'b1, 16'h0000);
         `CHK(pin[0], t != 2'h1);
         fl(32'sh0000_0008, 1'b1, 1'b1, 16'h0000);
         `CHK(pin[0], 1'b0);
      end
      `CHK(oe, 3'h7);
      `CHK(pin[1], 1'b1);
      $display("test done flag done");
   endtask
   task automatic t_done_win();
      i_host.wr(pssl_pkg::OFS_CTRL, 32'h0000_0004);
      i_host.wr(pssl_pkg::OFS_DONE_WIN, 32'h0000_0000);
      fl(32'sh0000_0000, 1'b0, 1'b0, 16'h0000);
      `CHK(pin[0], 1'b1);
      fl(-32'sh0000_0001, 1'b0, 1'b0, 16'h0000);
      `CHK(pin[0], 1'b0);
      i_host.wr(pssl_pkg::OFS_DONE_WIN, 32'hFFFF_FFFF);
      i_host.rd(pssl_pkg::OFS_DONE_WIN, d);
      `CHK(d, 32'h4000_0000);
      fl(-32'sh4000_0000, 1'b0, 1'b0, 16'h0000);
      `CHK(pin[0], 1'b1);
      fl(32'sh4000_0001, 1'b0, 1'b0, 16'h0000);
      `CHK(pin[0], 1'b0);
      i_host.wr(pssl_pkg::OFS_DONE_WIN, 32'h0000_0007);
      $display("test done window done");
   endtask
   task automatic t_near();
      i_host.wr(pssl_pkg::OFS_NEAR_WIN, 32'h0000_000A);
      fl(32'sh0000_000A, 1'b0, 1'b0, 16'h0000);
      `CHK(pin[1], 1'b1);
      fl(32'sh0000_000B, 1'b0, 1'b0, 16'h0000);
      `CHK(pin[1], 1'b0);
      fl(-32'sh0000_1388, 1'b0, 1'b0, 16'h0000);
      `CHK(pin[1], 1'b1);
      i_host.wr(pssl_pkg::OFS_NEAR_WIN, 32'h0000_0000);
      i_host.rd(pssl_pkg::OFS_NEAR_WIN, d);
      `CHK(d, 32'h0000_0001);
      fl(32'sh0000_0002, 1'b0, 1'b0, 16'h0000);
      `CHK(pin[1], 1'b0);
      i_host.wr(pssl_pkg::OFS_ALLOC, 32'h0000_0005);
      fl(32'sh0000_0001, 1'b1, 1'b1, 16'h0000);
      `CHK({oe, pin[1:0]}, 5'h15);
      $display("test near done");
   endtask
   // external against internal limits, every basis and motor kind
   task automatic t_limit();
      i_host.wr(pssl_pkg::OFS_ALLOC, 32'h0000_0007);
      i_host.wr(pssl_pkg::OFS_MAX_SPD, 32'h0000_2EE0);
      i_host.wr(pssl_pkg::OFS_EXT_LIM, 32'h0000_01F4);
      i_host.wr(pssl_pkg::OFS_CTRL, 32'h0000_0020);
      sp(16'h01F3);
      `CHK(lim, 16'h2710);
      i_host.wr(pssl_pkg::OFS_CTRL, 32'h0000_0024);
      sp(16'h01F3);
      `CHK({lim, pin[2]}, {16'h01F4, 1'b0});
      sp(16'h01F4);
      `CHK(pin[2], 1'b1);
      i_host.wr(pssl_pkg::OFS_EXT_LIM, 32'h0000_FFFF);
      i_host.wr(pssl_pkg::OFS_ROT_LIM, 32'h0000_07D0);
      sp(16'h01F4);
      `CHK({lim, pin[2]}, {16'h07D0, 1'b0});
      i_host.wr(pssl_pkg::OFS_LIN_LIM, 32'h0000_05DC);
      i_host.wr(pssl_pkg::OFS_CTRL, 32'h0000_0034);
      sp(16'h01F4);
      `CHK(lim, 16'h05DC);
      i_host.wr(pssl_pkg::OFS_ROT_LIM, 32'h0000_2710);
      i_host.wr(pssl_pkg::OFS_OVS_SPD, 32'h0000_2328);
      i_host.wr(pssl_pkg::OFS_CTRL, 32'h0000_002C);
      sp(16'h01F4);
      `CHK(lim, 16'h2328);
      i_host.wr(pssl_pkg::OFS_MAX_SPD, 32'h0000_1F40);
      i_host.wr(pssl_pkg::OFS_CTRL, 32'h0000_0024);
      sp(16'h2328);
      `CHK({lim, pin[2]}, {16'h1F40, 1'b1});
      i_host.rd(pssl_pkg::OFS_STATUS, d);
      `CHK(d, {13'h0000, 16'h1F40, 3'h7});
      i_host.wr(pssl_pkg::OFS_ROT_LIM, 32'h0000_4E20);
      i_host.rd(pssl_pkg::OFS_ROT_LIM, d);
      `CHK(d, 32'h0000_2710);
      i_host.wr(pssl_pkg::OFS_CTRL, 32'h0000_0004);
      sp(16'hFFFF);
      `CHK(pin[2], 1'b0);
      $display("test limit done");
   endtask
   // sticky status, mask, write-one clear
   task automatic t_irq();
      fl(32'sh0000_0064, 1'b1, 1'b1, 16'h0000);
      i_host.wr(pssl_pkg::OFS_IRQ_MASK, 32'h0000_0001);
      i_host.wr(pssl_pkg::OFS_IRQ_STAT, 32'h0000_0007);
      fl(32'sh0000_0064, 1'b1, 1'b1, 16'h0000);
      `CHK(irq, 1'b0);
      sp(16'h0000);
      `CHK(irq, 1'b1);
      i_host.rd(pssl_pkg::OFS_IRQ_STAT, d);
      `CHK(d[0], 1'b1);
      i_host.wr(pssl_pkg::OFS_IRQ_STAT, 32'h0000_0001);
      sp(16'h0000);
      `CHK(irq, 1'b0);
      i_host.wr(pssl_pkg::OFS_IRQ_MASK, 32'h0000_0000);
      fl(32'sh0000_0064, 1'b1, 1'b1, 16'h0000);
      sp(16'h0000);
      `CHK(irq, 1'b0);
      $display("test irq done");
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // main sequence after a four cycle reset
   initial begin
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      t_reset();
      t_done();
      t_done_win();
      t_near();
      t_limit();
      t_irq();
      conclude();
   end
   // hang guard, far past the test length
   initial begin
      #50000;
      n_fail++;
      conclude();
   end
endmodule
`default_nettype wire
